// File: hw/dual_clock_fifo_port_control.sv
// fifo storage and port control with pin synchronisers, flags and offset registers
`timescale 1ns/1ps

// ==========================================
// storage fifo
module fifo_store #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 32
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_clear,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data,
	output logic [$clog2(DEPTH+1)-1:0] o_count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [CW-1:0] count_ff;
	logic push, pop;
	assign o_ready = (count_ff != CW'(DEPTH));
	assign o_valid = (count_ff != '0);
	assign o_data = mem[rd_ptr_ff];
	assign o_count = count_ff;
	assign push = i_valid & o_ready;
	assign pop = i_ready & o_valid;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else if (i_clear) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule : fifo_store

// Functional notes
// [R1] master reset low returns write and read pointers to the first location
// [R2] controller must apply master reset after power-up before writing
// [R3] master reset drives half-level, almost-full and almost-empty indicators high
// [R4] master reset: empty indicator low in standard mode, high in fall-through mode
// [R5] master reset clears output register, loads both offsets with 0x07f
// [R6] write enable low and not full stores data on each write clock rise
// [R7] standard mode: full indicator low when full, high after read; write clock
// [R8] fall-through: input ready high when full, low after read; write clock
// [R9] write enable ignored while full in either mode
// [R10] read enable low and not empty loads next word into output register
// [R11] standard: every word needs a read; empty indicator tracks on read clock
// [R12] read enable ignored while empty, output register unchanged
// [R13] fall-through: first word appears on third read clock rise without read
// [R14] fall-through: after last word shown, a true read raises output ready
// [R15] output enable low drives the data bus, high floats it
// [R16] load and write enable low write offsets empty, full, empty, cyclically
// [R17] partial offset loads allowed; next load continues the sequence
// [R18] load low with write enable high: no offset pointer advance, no write
// [R19] load and read enable low read offsets back, standard mode only
// [R20] controller writes zero to unused offset bits; bits 17..12 unused
// [R21] controller should not read and write offsets at once
// [R22] board ties chain head select low on first chained device only
// [R23] board chains write and read chain inputs to previous device outputs
// [R24] timing mode chosen during master reset from head select and chain inputs
// [R25] standard full after 4096 writes, fall-through after 4097
module dual_clock_fifo_port_control #(
	parameter int DEPTH = fifo_ctl_pkg::DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_write_clock,
	input wire logic i_read_clock,
	input wire logic [fifo_ctl_pkg::DATA_W-1:0] i_write_data_in,
	input wire logic i_write_enable_n,
	input wire logic i_read_enable_n,
	input wire logic i_offset_load_select_n,
	input wire logic i_output_enable_n,
	input wire logic i_master_reset_n,
	input wire logic i_chain_head_select,
	input wire logic i_write_chain_in_n,
	input wire logic i_read_chain_in_n,
	output logic [fifo_ctl_pkg::DATA_W-1:0] o_read_data_out,
	output logic o_read_data_oe,
	output logic o_full_indicator,
	output logic o_empty_indicator,
	output logic o_half_level_indicator_n,
	output logic o_almost_full_indicator_n,
	output logic o_almost_empty_indicator_n
);
	import fifo_ctl_pkg::*;
	localparam int CW = $clog2(DEPTH+1);
	localparam int FW = ((CW > OFS_W) ? CW : OFS_W) + 2;
	// ==========================================
	// mode strap decode
	// single-device wiring (a chain input grounded) with head select high picks fall-through
	function automatic mode_t strap_mode(input logic head, input logic wchain_n, input logic rchain_n);
		return (head && !(wchain_n && rchain_n)) ? MODE_FALL : MODE_STD;
	endfunction : strap_mode
	// ==========================================
	// pin synchronisers: every pin passes two flops before use
	logic [PIN_W-1:0] pin_raw, sync1_ff, sync2_ff;
	logic wclk_prev_ff, rclk_prev_ff;
	logic [DATA_W-1:0] din;
	logic wclk_s, rclk_s, wen_n, ren_n, load_n, oe_n, mrst_n, head_s, wchain_n, rchain_n;
	assign pin_raw = {i_write_data_in, i_write_clock, i_read_clock, i_write_enable_n, i_read_enable_n,
		i_offset_load_select_n, i_output_enable_n, i_master_reset_n, i_chain_head_select,
		i_write_chain_in_n, i_read_chain_in_n};
	assign {din, wclk_s, rclk_s, wen_n, ren_n, load_n, oe_n, mrst_n, head_s, wchain_n, rchain_n} = sync2_ff;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			wclk_prev_ff <= 1'b0;
			rclk_prev_ff <= 1'b0;
		end else begin
			sync1_ff <= pin_raw;
			sync2_ff <= sync1_ff;
			wclk_prev_ff <= wclk_s;
			rclk_prev_ff <= rclk_s;
		end
	end

	logic wr_edge, rd_edge, in_reset;
	assign wr_edge = wclk_s & ~wclk_prev_ff;
	assign rd_edge = rclk_s & ~rclk_prev_ff;
	assign in_reset = ~mrst_n;

	// ==========================================
	// timing mode, caught while master reset is held
	mode_t mode_ff;
	logic fall_thru;
	assign fall_thru = (mode_ff == MODE_FALL);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_ff <= MODE_STD;
		end else if (in_reset) begin
			mode_ff <= strap_mode(head_s, wchain_n, rchain_n); // R24
		end
	end

	// ==========================================
	// storage
	logic push, pop, mem_ready, mem_valid;
	logic [DATA_W-1:0] mem_data;
	logic [CW-1:0] mem_count;
	fifo_store #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_store (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_clear(in_reset), // R1
		.i_valid(push),
		.o_ready(mem_ready),
		.i_data(din),
		.o_valid(mem_valid),
		.i_ready(pop),
		.o_data(mem_data),
		.o_count(mem_count)
	);

	// ==========================================
	// write side: data and offset loads on write clock rises
	logic [OFS_W-1:0] empty_threshold_offset_ff, full_threshold_offset_ff;
	logic wr_ofs_ptr_ff, ofs_wr;
	// a full store back-pressures the write; in fall-through the output register is the extra word
	assign push = wr_edge & ~wen_n & load_n & mem_ready & ~in_reset; // R6 R9 R25
	assign ofs_wr = wr_edge & ~wen_n & ~load_n & ~in_reset; // R16 R18
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			empty_threshold_offset_ff <= OFS_RESET;
			full_threshold_offset_ff <= OFS_RESET;
			wr_ofs_ptr_ff <= OFS_SEL_EMPTY;
		end else if (in_reset) begin
			empty_threshold_offset_ff <= OFS_RESET; // R5
			full_threshold_offset_ff <= OFS_RESET;
			wr_ofs_ptr_ff <= OFS_SEL_EMPTY;
		end else if (ofs_wr) begin
			if (wr_ofs_ptr_ff == OFS_SEL_EMPTY) begin
				empty_threshold_offset_ff <= din[OFS_W-1:0]; // R16
			end else begin
				full_threshold_offset_ff <= din[OFS_W-1:0];
			end
			// pointer only moves on a real load, so a partial load resumes in sequence
			wr_ofs_ptr_ff <= ~wr_ofs_ptr_ff; // R17
		end
	end

	// ==========================================
	// read side: output register, offset read-back, fall-through delivery
	logic [DATA_W-1:0] out_ff;
	logic out_valid_ff, rd_ofs_ptr_ff;
	logic [1:0] fall_cnt_ff;
	logic ofs_rd, std_rd, fw_load;
	assign ofs_rd = rd_edge & ~ren_n & ~load_n & ~fall_thru & ~in_reset; // R19
	assign std_rd = rd_edge & ~ren_n & load_n & ~fall_thru & mem_valid & ~in_reset; // R10 R11 R12
	// fall-through refills when the output register is empty (after the delay) or on a true read
	assign fw_load = rd_edge & fall_thru & load_n & mem_valid & ~in_reset &
		(out_valid_ff ? ~ren_n : (fall_cnt_ff == FALL_EDGES - 2'h1)); // R13
	assign pop = std_rd | fw_load;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_ff <= OUT_RESET;
		end else if (in_reset) begin
			out_ff <= OUT_RESET; // R5
		end else if (ofs_rd) begin
			out_ff <= {{(DATA_W-OFS_W){1'b0}}, (rd_ofs_ptr_ff == OFS_SEL_EMPTY) ?
				empty_threshold_offset_ff : full_threshold_offset_ff}; // R19 R20
		end else if (pop) begin
			out_ff <= mem_data; // R10
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_ofs_ptr_ff <= OFS_SEL_EMPTY;
		end else if (in_reset) begin
			rd_ofs_ptr_ff <= OFS_SEL_EMPTY;
		end else if (ofs_rd) begin
			rd_ofs_ptr_ff <= ~rd_ofs_ptr_ff; // R19
		end
	end

	// counts read clock rises seen while a first word waits to fall through
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fall_cnt_ff <= 2'h0;
		end else if (in_reset || !fall_thru || out_valid_ff || !mem_valid || fw_load) begin
			fall_cnt_ff <= 2'h0;
		end else if (rd_edge) begin
			fall_cnt_ff <= fall_cnt_ff + 2'h1; // R13
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_valid_ff <= 1'b0;
		end else if (in_reset) begin
			out_valid_ff <= 1'b0;
		end else if (fw_load) begin
			out_valid_ff <= 1'b1;
		end else if (rd_edge && fall_thru && !ren_n) begin
			// true read with nothing behind it: data stays, output ready goes high
			out_valid_ff <= 1'b0; // R14
		end
	end

	// ==========================================
	// status flags
	logic [CW:0] total;
	assign total = {1'b0, mem_count} + {{CW{1'b0}}, out_valid_ff & fall_thru};

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_full_indicator <= 1'b1;
		end else if (in_reset) begin
			o_full_indicator <= ~fall_thru;
		end else if (wr_edge) begin
			// full and input ready share the pin with opposite sense
			if (fall_thru) begin
				o_full_indicator <= ~mem_ready & out_valid_ff; // R8 R25
			end else begin
				o_full_indicator <= mem_ready; // R7 R25
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_empty_indicator <= 1'b0;
		end else if (in_reset) begin
			o_empty_indicator <= fall_thru; // R4
		end else if (rd_edge) begin
			if (fall_thru) begin
				o_empty_indicator <= ~(fw_load | (out_valid_ff & ren_n)); // R14
			end else begin
				o_empty_indicator <= mem_valid & ~(std_rd && mem_count == CW'(1)); // R11
			end
		end
	end

	// thresholds are simple level compares; async/sync flag options are not modelled
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_half_level_indicator_n <= 1'b1;
			o_almost_full_indicator_n <= 1'b1;
			o_almost_empty_indicator_n <= 1'b1;
		end else if (in_reset) begin
			o_half_level_indicator_n <= 1'b1; // R3
			o_almost_full_indicator_n <= 1'b1;
			o_almost_empty_indicator_n <= 1'b1;
		end else begin
			o_half_level_indicator_n <= ~(total > (CW+1)'(DEPTH/2));
			o_almost_full_indicator_n <= ~(FW'(total) + FW'(full_threshold_offset_ff) >= FW'(DEPTH));
			o_almost_empty_indicator_n <= ~(FW'(total) <= FW'(empty_threshold_offset_ff));
		end
	end

	// ==========================================
	// output drive; the bus itself is resolved outside from the enable
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_read_data_out <= OUT_RESET;
			o_read_data_oe <= 1'b0;
		end else begin
			o_read_data_out <= out_ff;
			o_read_data_oe <= ~oe_n; // R15
		end
	end
endmodule : dual_clock_fifo_port_control

// File: hw/fifo_ctl_pkg.sv
// shared constants for the dual-clock fifo port control
package fifo_ctl_pkg;
	// ==========================================
	// widths and depth
	localparam int DATA_W = 18;
	localparam int OFS_W = 12;
	localparam int DEPTH = 4096;
	// ==========================================
	// reset values
	localparam logic [OFS_W-1:0] OFS_RESET = 12'h07f;
	localparam logic [DATA_W-1:0] OUT_RESET = 18'h00000;
	// ==========================================
	// offset register sequence
	localparam logic OFS_SEL_EMPTY = 1'b0;
	localparam logic OFS_SEL_FULL = 1'b1;
	// ==========================================
	// fall-through delivery: the first word shows on this rising read clock edge
	localparam logic [1:0] FALL_EDGES = 2'h3;
	// ==========================================
	// pin synchroniser layout
	localparam int PIN_W = DATA_W + 10;
	// ==========================================
	// timing mode
	typedef enum logic [1:0] {
		MODE_STD = 2'b01,
		MODE_FALL = 2'b10
	} mode_t;
endpackage : fifo_ctl_pkg

// File: tb/fifo_port_monitor.sv
// checker on the fifo port control pins
`timescale 1ns/1ps
module fifo_port_monitor #(
	parameter int DEPTH = 4096
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_write_clock,
	input wire logic i_read_clock,
	input wire logic i_output_enable_n,
	input wire logic i_master_reset_n,
	input wire logic i_chain_head_select,
	input wire logic i_write_chain_in_n,
	input wire logic i_read_chain_in_n,
	input wire logic [fifo_ctl_pkg::DATA_W-1:0] o_read_data_out,
	input wire logic o_read_data_oe,
	input wire logic o_full_indicator,
	input wire logic o_empty_indicator,
	input wire logic o_half_level_indicator_n,
	input wire logic o_almost_full_indicator_n,
	input wire logic o_almost_empty_indicator_n
);
	import fifo_ctl_pkg::*;
	// ====
	// cycles since a link clock rise or master reset; saturate so they never wrap
	logic [3:0] wcnt_ff;
	logic [3:0] rcnt_ff;
	logic [3:0] mcnt_ff;
	logic fall_thru;
	assign fall_thru = i_chain_head_select && !(i_write_chain_in_n && i_read_chain_in_n);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) wcnt_ff <= 4'h0;
		else if ($rose(i_write_clock)) wcnt_ff <= 4'h0;
		else if (wcnt_ff != 4'hf) wcnt_ff <= wcnt_ff + 4'h1;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) rcnt_ff <= 4'h0;
		else if ($rose(i_read_clock)) rcnt_ff <= 4'h0;
		else if (rcnt_ff != 4'hf) rcnt_ff <= rcnt_ff + 4'h1;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) mcnt_ff <= 4'h0;
		else if (!i_master_reset_n) mcnt_ff <= 4'h0;
		else if (mcnt_ff != 4'hf) mcnt_ff <= mcnt_ff + 4'h1;
	end
	// ====
	// assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_oe_drive: assert property ($fell(i_output_enable_n) |-> ##[1:4] o_read_data_oe)
		else $error("bus not driven after output enable");
	a_oe_float: assert property ($rose(i_output_enable_n) |-> ##[1:4] !o_read_data_oe)
		else $error("bus still driven after output disable");
	a_reset_flags: assert property (!i_master_reset_n [*6] |->
		o_half_level_indicator_n && o_almost_full_indicator_n && o_almost_empty_indicator_n)
		else $error("level flags not high in master reset");
	a_reset_data: assert property (!i_master_reset_n [*6] |-> o_read_data_out == OUT_RESET)
		else $error("output register not cleared");
	a_reset_empty: assert property (!i_master_reset_n [*6] |-> o_empty_indicator == fall_thru)
		else $error("empty pin wrong in master reset");
	a_reset_full: assert property (!i_master_reset_n [*6] |-> o_full_indicator == !fall_thru)
		else $error("full pin wrong for strapped mode");
	a_full_timing: assert property ($changed(o_full_indicator) |-> wcnt_ff < 4'h7 || mcnt_ff < 4'h6)
		else $error("full pin moved without a write clock rise");
	a_empty_timing: assert property ($changed(o_empty_indicator) |-> rcnt_ff < 4'h7 || mcnt_ff < 4'h6)
		else $error("empty pin moved without a read clock rise");
	a_data_timing: assert property ($changed(o_read_data_out) |-> rcnt_ff < 4'h7
		|| mcnt_ff < 4'h6 || !o_read_data_oe || !$past(o_read_data_oe))
		else $error("output data moved without a read clock rise");
	cover property ($fell(o_full_indicator));
	cover property ($rose(o_empty_indicator));
	cover property ($rose(i_output_enable_n));
endmodule : fifo_port_monitor

bind dual_clock_fifo_port_control fifo_port_monitor #(.DEPTH(DEPTH)) u_mon (
	.i_clk, .i_rst_n, .i_write_clock, .i_read_clock, .i_output_enable_n,
	.i_master_reset_n, .i_chain_head_select, .i_write_chain_in_n, .i_read_chain_in_n,
	.o_read_data_out, .o_read_data_oe, .o_full_indicator, .o_empty_indicator,
	.o_half_level_indicator_n, .o_almost_full_indicator_n, .o_almost_empty_indicator_n
);

// File: tb/fifo_host_model.sv
// producer and consumer model: free-running link clocks, enables, load select, data
`timescale 1ns/1ps
module fifo_host_model (
	input wire logic i_clk,
	output logic o_write_clock,
	output logic o_read_clock,
	output logic [fifo_ctl_pkg::DATA_W-1:0] o_write_data,
	output logic o_write_enable_n,
	output logic o_read_enable_n,
	output logic o_load_n
);
	import fifo_ctl_pkg::*;
	// ====
	// link clocks run free; read clock skewed so edges never coincide
	initial begin
		o_write_clock = 1'b0;
		forever #160 o_write_clock = ~o_write_clock;
	end
	initial begin
		o_read_clock = 1'b0;
		#57;
		forever #160 o_read_clock = ~o_read_clock;
	end
	initial begin
		o_write_data = 18'h00000;
		o_write_enable_n = 1'b1;
		o_read_enable_n = 1'b1;
		o_load_n = 1'b1;
	end
	// ====
	// one rise per access; data lines turn to the inverse once the word is taken
	task automatic wr(input logic [DATA_W-1:0] d);
		@(negedge o_write_clock);
		@(posedge i_clk);
		o_write_data <= d;
		o_write_enable_n <= 1'b0;
		@(negedge o_write_clock);
		@(posedge i_clk);
		o_write_enable_n <= 1'b1;
		o_write_data <= ~d;
	endtask : wr
	// reads and writes are never overlapped: tasks are called one at a time
	task automatic rd;
		@(negedge o_read_clock);
		@(posedge i_clk);
		o_read_enable_n <= 1'b0;
		@(negedge o_read_clock);
		@(posedge i_clk);
		o_read_enable_n <= 1'b1;
		repeat (4) @(posedge i_clk);
	endtask : rd
	task automatic set_load(input logic v);
		@(posedge i_clk);
		o_load_n <= v;
	endtask : set_load
endmodule : fifo_host_model

// File: tb/dual_clock_fifo_port_control_bench.sv
// self-checking bench for the fifo port control
`timescale 1ns/1ps
module dual_clock_fifo_port_control_bench;
	import fifo_ctl_pkg::*;
	// short depth keeps the fill tests brief
	localparam int TDEPTH = 8;
	logic clk, rst_n, mr_n, head, wchain_n, rchain_n, oe_n;
	logic wclk, rclk, wen_n, ren_n, load_n, q_oe, full, empty, half_n, af_n, ae_n;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] q;
	int error_cnt;
	int n_compared;
	fifo_host_model host (.i_clk(clk), .o_write_clock(wclk), .o_read_clock(rclk), .o_write_data(wdata),
		.o_write_enable_n(wen_n), .o_read_enable_n(ren_n), .o_load_n(load_n));
	dual_clock_fifo_port_control #(.DEPTH(TDEPTH)) DUT (.i_clk(clk), .i_rst_n(rst_n),
		.i_write_clock(wclk), .i_read_clock(rclk), .i_write_data_in(wdata), .i_write_enable_n(wen_n),
		.i_read_enable_n(ren_n), .i_offset_load_select_n(load_n), .i_output_enable_n(oe_n),
		.i_master_reset_n(mr_n), .i_chain_head_select(head), .i_write_chain_in_n(wchain_n),
		.i_read_chain_in_n(rchain_n), .o_read_data_out(q), .o_read_data_oe(q_oe),
		.o_full_indicator(full), .o_empty_indicator(empty), .o_half_level_indicator_n(half_n),
		.o_almost_full_indicator_n(af_n), .o_almost_empty_indicator_n(ae_n));
	// ====
	// helpers
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		#1;
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	task automatic mreset(input logic [2:0] strap, input logic fall);
		@(posedge clk);
		{head, wchain_n, rchain_n} <= strap;
		mr_n <= 1'b0;
		repeat (8) @(posedge clk);
		check(empty, fall);
		check({half_n, af_n, ae_n}, 3'h7);
		check(q, OUT_RESET);
		check(full, !fall);
		@(posedge clk);
		mr_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : mreset
	// ====
	// stimulus
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#500000;
		error_cnt++;
		results();
	end
	initial begin
		rst_n = 1'b0;
		mr_n = 1'b0;
		head = 1'b0;
		wchain_n = 1'b1;
		rchain_n = 1'b1;
		oe_n = 1'b0;
		error_cnt = 0;
		n_compared = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		mreset(3'h3, 1'b0);
		// idle write rises with load low must not move the offset pointer
		host.set_load(1'b0);
		repeat (24) @(posedge clk);
		host.rd();
		check(q, 18'h0007f);
		host.rd();
		check(q, 18'h0007f);
		host.wr(18'h00005);
		host.set_load(1'b1);
		repeat (16) @(posedge clk);
		host.set_load(1'b0);
		host.wr(18'h00abc);
		host.rd();
		check(q, 18'h00005);
		host.rd();
		check(q, 18'h00abc);
		host.set_load(1'b1);
		// fill to the brim, one extra word is refused
		for (int i = 0; i < TDEPTH - 1; i++) host.wr(18'h00100 + 18'(i));
		repeat (12) @(posedge clk);
		check(full, 1'b1);
		check(q, 18'h00abc);
		host.wr(18'h00107);
		host.wr(18'h00108);
		repeat (12) @(posedge clk);
		check(full, 1'b0);
		check(empty, 1'b1);
		host.rd();
		check(q, 18'h00100);
		repeat (16) @(posedge clk);
		check(full, 1'b1);
		for (int i = 1; i < TDEPTH; i++) begin
			host.rd();
			check(q, 18'h00100 + 18'(i));
		end
		repeat (16) @(posedge clk);
		check(empty, 1'b0);
		host.rd();
		check(q, 18'h00107);
		@(posedge clk) oe_n <= 1'b1;
		repeat (6) @(posedge clk);
		check(q_oe, 1'b0);
		@(posedge clk) oe_n <= 1'b0;
		repeat (6) @(posedge clk);
		check(q_oe, 1'b1);
		// fall-through: first word shows unasked, full at depth plus one
		mreset(3'h6, 1'b1);
		host.wr(18'h00155);
		repeat (48) @(posedge clk);
		check(q, 18'h00155);
		check(empty, 1'b0);
		for (int i = 1; i <= TDEPTH; i++) host.wr(18'h00155 + 18'(i));
		repeat (12) @(posedge clk);
		check(full, 1'b1);
		for (int i = 1; i <= TDEPTH; i++) begin
			host.rd();
			check(q, 18'h00155 + 18'(i));
		end
		check(full, 1'b0);
		check(empty, 1'b0);
		host.rd();
		repeat (12) @(posedge clk);
		check(empty, 1'b1);
		check(q, 18'h0015d);
		// head select high with both chain inputs high stays standard; nothing survives the reset
		mreset(3'h7, 1'b0);
		host.rd();
		check(q, OUT_RESET);
		check(empty, 1'b0);
		results();
	end
endmodule : dual_clock_fifo_port_control_bench
